// ### logic/scm_serial_ch0_mode_control.sv
// Mode/control registers and serial engine, serial channel 0.
// Assumes pin inputs synchronous to clock and an AXI4-Lite master.
//
// Notes on behaviour
// RL1 - Mode register is a byte; its top three bits also take single-bit set/clear.
// RL2 - Bit 6 of the mode register is read-only; written values are dropped.
// RL3 - Reset clears mode register and bus control register to zero.
// RL4 - Clock select 00 takes external pin clock; 01 takes timer output, pin drives.
// RL5 - Select 10 gives fx/16 three-wire, fx/64 bus modes; 11 gives fx/8.
// RL6 - Enable and mode bits 3,2 decode halt, three-wire, addressed bus, two-wire.
// RL7 - Wake-up off: interrupt request on every completed transfer.
// RL8 - Wake-up on in bus mode: interrupt only on matching first address; line released.
// RL9 - Wake-up does not end busy; busy ends at next falling clock after release.
// RL10 - Software releases busy and sees data line high before setting wake-up.
// RL11 - Address match flag reads one when slave address equals shift register.
// RL12 - Address match flag meaningful only outside a transfer.
// RL13 - Enable off: shifting stops, counter clears, request held, pins are port except the clock pin, driven high unless clock select is 00.
// RL14 - Enable on: shifting allowed, counter counts, request may set, pins serve mode.
// RL15 - Clock pin state follows enable and clock select; internal clock idles high.
// RL16 - Software masks interrupts, clears enable, then clears request mid-transfer.
// RL17 - Bus control register takes only single-bit set, clear and test.
// RL18 - Release trigger sets the serial output latch in every mode.
// RL19 - Command trigger clears the serial output latch in every mode.
// RL20 - Both trigger bits return to zero by themselves after acting.
// RL21 - Writing shift register starts a transfer; it halts after eight bits.
// RL22 - Bus and two-wire modes: bit 4 picks which open-drain line carries data.
// RL23 - Three-wire: push-pull output, plain input, bit 4 picks MSB or LSB first.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module scm_serial_ch0_mode_control
    import scm_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            nrst,
    input  wire scm_axi_req_type axiReq,
    output scm_axi_rsp_type      axiRsp,
    input  wire logic            timerOut,
    input  wire logic            clockPinIn,
    output logic                 clockPinOut,
    output logic                 clockPinOe,
    output logic                 serialOutPin,
    output logic                 serialOutOe,
    input  wire logic            serialInPin,
    input  wire logic            busLineAIn,
    output logic                 busLineAOut,
    output logic                 busLineAOe,
    input  wire logic            busLineBIn,
    output logic                 busLineBOut,
    output logic                 busLineBOe,
    output logic                 serialIrqRequest
);

    // ==========================================================
    // Address decode
    function automatic scm_reg_type decodeAddr(input logic [11:0] addr);
        case (addr)
            ADDR_MODE_CONTROL: decodeAddr = REG_MODE;
            ADDR_BUS_CONTROL:  decodeAddr = REG_BUS;
            ADDR_SLAVE_ADDR:   decodeAddr = REG_SLAVE;
            ADDR_SHIFT:        decodeAddr = REG_SHIFT;
            ADDR_BIT_OP:       decodeAddr = REG_BITOP;
            ADDR_STATUS:       decodeAddr = REG_STATUS;
            default:           decodeAddr = REG_NONE;
        endcase
    endfunction

    logic [7:0]  mode_reg;
    logic [7:0]  busCtrl_reg;
    logic [1:0]  trig_reg;
    logic [7:0]  slaveAddr_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bitCnt_reg;
    logic        active_reg;
    logic        irq_reg;
    logic        soLatch_reg;
    logic        busy_reg;
    logic        relSeen_reg;
    logic        cmdSeen_reg;
    logic        addrPending_reg;
    logic        genClk_reg;
    logic [5:0]  divCnt_reg;
    logic        prevClk_reg;
    logic        prevData_reg;

    logic        awHeld_reg;
    logic [11:0] awAddr_reg;
    logic        wHeld_reg;
    logic [31:0] wData_reg;
    logic        wStrb0_reg;
    logic        bValid_reg;
    logic [1:0]  bResp_reg;
    logic        rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0]  rResp_reg;

    // ==========================================================
    // Bus slave
    scm_reg_type wrSel;
    scm_reg_type rdSel;
    logic        wrFire;
    logic        wrBad;
    logic        wrOk;
    logic [2:0]  bitIdx;
    logic        bitVal;
    logic        bitOpMode;
    logic        bitOpBus;
    logic        shiftWrite;
    logic        irqClear;

    assign wrSel = decodeAddr(awAddr_reg);
    assign rdSel = decodeAddr(axiReq.araddr);
    assign wrFire = awHeld_reg && wHeld_reg && !bValid_reg;
    // Word writes to bus control refused
    assign wrBad = (wrSel == REG_NONE) || (wrSel == REG_BUS); // RL17
    assign wrOk = wrFire && !wrBad && wStrb0_reg;
    assign bitIdx = wData_reg[BITOP_IDX_HI:0];
    assign bitVal = wData_reg[BITOP_VALUE];
    assign bitOpMode = wrOk && (wrSel == REG_BITOP) && !wData_reg[BITOP_TARGET];
    assign bitOpBus = wrOk && (wrSel == REG_BITOP) && wData_reg[BITOP_TARGET];
    assign shiftWrite = wrOk && (wrSel == REG_SHIFT);
    assign irqClear = wrOk && (wrSel == REG_STATUS) && wData_reg[STATUS_IRQ];

    always_comb begin
        axiRsp.awready = !awHeld_reg;
        axiRsp.wready = !wHeld_reg;
        axiRsp.bvalid = bValid_reg;
        axiRsp.bresp = bResp_reg;
        axiRsp.arready = !rValid_reg;
        axiRsp.rvalid = rValid_reg;
        axiRsp.rdata = rData_reg;
        axiRsp.rresp = rResp_reg;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 12'h000;
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h0000_0000;
            wStrb0_reg <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg <= RESP_OKAY;
        end else begin
            if (axiReq.awvalid && !awHeld_reg) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= axiReq.awaddr;
            end
            if (axiReq.wvalid && !wHeld_reg) begin
                wHeld_reg <= 1'b1;
                wData_reg <= axiReq.wdata;
                wStrb0_reg <= axiReq.wstrb[0];
            end
            if (wrFire) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg <= wrBad ? RESP_SLVERR : RESP_OKAY;
            end else if (bValid_reg && axiReq.bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    logic [7:0] modeView;
    logic [7:0] busView;
    logic       addrMatch;
    assign addrMatch = (slaveAddr_reg == shift_reg); // RL11 RL12
    // Match bit is the live comparator
    assign modeView = {mode_reg[7], addrMatch, mode_reg[5:0]}; // RL2
    always_comb begin
        busView = 8'h00;
        busView[BUS_BUSY_ENABLE] = busCtrl_reg[BUS_BUSY_ENABLE];
        busView[BUS_REL_SEEN] = relSeen_reg;
        busView[BUS_CMD_SEEN] = cmdSeen_reg;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= RESP_OKAY;
        end else if (axiReq.arvalid && !rValid_reg) begin
            rValid_reg <= 1'b1;
            rResp_reg <= (rdSel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            case (rdSel)
                REG_MODE:   rData_reg <= {24'h000000, modeView};
                REG_BUS:    rData_reg <= {24'h000000, busView};
                REG_SLAVE:  rData_reg <= {24'h000000, slaveAddr_reg};
                REG_SHIFT:  rData_reg <= {24'h000000, shift_reg};
                REG_STATUS: rData_reg <= {30'h00000000, active_reg, irq_reg};
                default:    rData_reg <= 32'h0000_0000;
            endcase
        end else if (rValid_reg && axiReq.rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            mode_reg <= MODE_RESET; // RL3
        end else if (wrOk && (wrSel == REG_MODE)) begin
            mode_reg <= wData_reg[7:0] & 8'hbf; // RL1 RL2
        end else if (bitOpMode && bitIdx >= 3'(MODE_BITOP_LO) && bitIdx != 3'(MODE_MATCH)) begin
            mode_reg[bitIdx] <= bitVal; // RL1
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            busCtrl_reg <= BUS_RESET; // RL3
        end else if (bitOpBus && bitIdx == 3'(BUS_BUSY_ENABLE)) begin
            busCtrl_reg[BUS_BUSY_ENABLE] <= bitVal; // RL17
        end
    end

    // Triggers live one cycle and read back as zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            trig_reg <= 2'h0;
        end else begin
            trig_reg[1] <= bitOpBus && bitVal && bitIdx == 3'(BUS_RELEASE_TRIG); // RL20
            trig_reg[0] <= bitOpBus && bitVal && bitIdx == 3'(BUS_COMMAND_TRIG); // RL20
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            slaveAddr_reg <= 8'h00;
        end else if (wrOk && (wrSel == REG_SLAVE)) begin
            slaveAddr_reg <= wData_reg[7:0];
        end
    end

    // ==========================================================
    // Mode decode
    scm_mode_type opMode;
    logic         enable;
    logic         busMode;
    logic         anyBus;
    logic         lineSel;
    logic         wakeup;
    logic [1:0]   clkSel;
    assign enable = mode_reg[MODE_ENABLE];
    assign lineSel = mode_reg[MODE_LINE_SEL];
    assign wakeup = mode_reg[MODE_WAKEUP];
    assign clkSel = mode_reg[MODE_CLK_HI:MODE_CLK_LO];

    always_comb begin
        if (!enable) begin
            opMode = MODE_HALT; // RL6
        end else if (!mode_reg[MODE_HI]) begin
            opMode = MODE_THREE_WIRE;
        end else if (!mode_reg[MODE_LO]) begin
            opMode = MODE_ADDRESSED_BUS;
        end else begin
            opMode = MODE_TWO_WIRE;
        end
    end
    assign busMode = (opMode == MODE_ADDRESSED_BUS);
    assign anyBus = busMode || (opMode == MODE_TWO_WIRE);

    // ==========================================================
    // Serial clock source
    logic [5:0] halfPeriod;
    logic       internalClk;
    logic       srcClk;
    logic       clkFall;
    logic       clkRise;
    logic       dataIn;
    always_comb begin
        case (clkSel)
            CLK_DIV_MID: halfPeriod = anyBus ? HALF_DIV64 : HALF_DIV16; // RL5
            default:     halfPeriod = HALF_DIV8; // RL5
        endcase
    end
    assign internalClk = clkSel[1];
    always_comb begin
        case (clkSel)
            CLK_EXTERNAL: srcClk = clockPinIn; // RL4
            CLK_TIMER:    srcClk = active_reg ? timerOut : 1'b1; // RL4
            default:      srcClk = genClk_reg;
        endcase
    end
    assign clkFall = prevClk_reg && !srcClk;
    assign clkRise = !prevClk_reg && srcClk;

    // Divider runs only in a transfer; clock idles high
    always_ff @(posedge clock) begin
        if (!nrst) begin
            divCnt_reg <= 6'h00;
            genClk_reg <= 1'b1;
        end else if (!active_reg || !internalClk) begin
            divCnt_reg <= 6'h00;
            genClk_reg <= 1'b1;
        end else if (divCnt_reg == halfPeriod - 6'h01) begin
            divCnt_reg <= 6'h00;
            genClk_reg <= !genClk_reg; // RL5
        end else begin
            divCnt_reg <= divCnt_reg + 6'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prevClk_reg <= 1'b1;
            prevData_reg <= 1'b1;
        end else begin
            prevClk_reg <= srcClk;
            prevData_reg <= dataIn;
        end
    end

    // ==========================================================
    // Shift engine
    logic lsbFirst;
    logic lastRise;
    assign lsbFirst = (opMode == MODE_THREE_WIRE) && lineSel; // RL23
    always_comb begin
        if (opMode == MODE_THREE_WIRE) begin
            dataIn = serialInPin; // RL23
        end else begin
            dataIn = lineSel ? busLineBIn : busLineAIn; // RL22
        end
    end
    assign lastRise = active_reg && clkRise && (bitCnt_reg == LAST_BIT);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            active_reg <= 1'b0;
            bitCnt_reg <= 3'h0;
        end else if (!enable) begin
            active_reg <= 1'b0; // RL13
            bitCnt_reg <= 3'h0; // RL13
        end else if (shiftWrite) begin
            active_reg <= 1'b1; // RL21 RL14
            bitCnt_reg <= 3'h0;
        end else if (active_reg && clkRise) begin
            bitCnt_reg <= bitCnt_reg + 3'h1; // RL14
            if (bitCnt_reg == LAST_BIT) begin
                active_reg <= 1'b0; // RL21
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            shift_reg <= 8'h00;
        end else if (shiftWrite) begin
            shift_reg <= wData_reg[7:0]; // RL21
        end else if (enable && active_reg && clkRise) begin
            if (lsbFirst) begin
                shift_reg <= {dataIn, shift_reg[7:1]}; // RL23
            end else begin
                shift_reg <= {shift_reg[6:0], dataIn};
            end
        end
    end

    // Triggers act in every mode
    always_ff @(posedge clock) begin
        if (!nrst) begin
            soLatch_reg <= 1'b1;
        end else if (trig_reg[1]) begin
            soLatch_reg <= 1'b1; // RL18
        end else if (trig_reg[0]) begin
            soLatch_reg <= 1'b0; // RL19
        end else if (enable && active_reg && clkFall) begin
            soLatch_reg <= lsbFirst ? shift_reg[0] : shift_reg[7];
        end
    end

    // ==========================================================
    // Bus events, wake-up and request
    logic relEvent;
    logic cmdEvent;
    logic irqSet;
    assign relEvent = busMode && srcClk && prevClk_reg && dataIn && !prevData_reg;
    assign cmdEvent = busMode && srcClk && prevClk_reg && !dataIn && prevData_reg;

    always_ff @(posedge clock) begin
        if (!nrst || !enable) begin
            relSeen_reg <= 1'b0;
            cmdSeen_reg <= 1'b0;
            addrPending_reg <= 1'b0;
        end else begin
            if (relEvent) begin
                relSeen_reg <= 1'b1;
                cmdSeen_reg <= 1'b0;
                addrPending_reg <= 1'b1;
            end else begin
                if (shiftWrite) begin
                    relSeen_reg <= 1'b0;
                    cmdSeen_reg <= 1'b0;
                end else if (cmdEvent) begin
                    cmdSeen_reg <= 1'b1;
                end
                if (lastRise) begin
                    addrPending_reg <= 1'b0;
                end
            end
        end
    end

    // Match includes the eighth bit
    logic finalMatch;
    assign finalMatch = lsbFirst ? 1'b0 : (slaveAddr_reg == {shift_reg[6:0], dataIn});
    always_comb begin
        if (wakeup && busMode) begin
            irqSet = lastRise && addrPending_reg && finalMatch; // RL8
        end else begin
            irqSet = lastRise; // RL7
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else if (irqSet) begin
            irq_reg <= 1'b1; // RL14
        end else if (irqClear) begin
            irq_reg <= 1'b0; // RL13
        end
    end
    assign serialIrqRequest = irq_reg;

    // Busy drops on a falling clock edge once busy enable is clear, or at once when enable is cleared
    always_ff @(posedge clock) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
        end else if (lastRise && busMode && busCtrl_reg[BUS_BUSY_ENABLE]) begin
            busy_reg <= 1'b1;
        end else if (!enable || (clkFall && !busCtrl_reg[BUS_BUSY_ENABLE])) begin
            busy_reg <= 1'b0; // RL9
        end
    end

    // ==========================================================
    // Pins
    logic pullLow;
    assign pullLow = busy_reg || (!soLatch_reg && !(wakeup && busMode)); // RL8 RL9

    always_comb begin
        clockPinOut = 1'b1;
        clockPinOe = 1'b0;
        if (clkSel != CLK_EXTERNAL) begin
            clockPinOe = 1'b1; // RL15
            clockPinOut = enable ? srcClk : 1'b1; // RL15
        end
    end

    assign serialOutPin = soLatch_reg;
    assign serialOutOe = (opMode == MODE_THREE_WIRE); // RL23 RL13
    assign busLineAOut = 1'b0;
    assign busLineBOut = 1'b0;
    assign busLineAOe = anyBus && !lineSel && pullLow; // RL22
    assign busLineBOe = anyBus && lineSel && pullLow; // RL22

endmodule // scm_serial_ch0_mode_control

`default_nettype wire

// ### logic/scm_pkg.sv
// Constants and bus carriers for the serial mode/control block.
// Assumes an AXI4-Lite master, 32-bit data, 12-bit byte address.
package scm_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [11:0] ADDR_MODE_CONTROL = 12'hfe0;
    localparam logic [11:0] ADDR_BUS_CONTROL  = 12'hfe4;
    localparam logic [11:0] ADDR_SLAVE_ADDR   = 12'hfe8;
    localparam logic [11:0] ADDR_SHIFT        = 12'hfec;
    localparam logic [11:0] ADDR_BIT_OP       = 12'hff0;
    localparam logic [11:0] ADDR_STATUS       = 12'hff4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BUS_RESET  = 8'h00;

    // ==========================================================
    // Mode register fields
    localparam int MODE_ENABLE   = 7;
    localparam int MODE_MATCH    = 6;
    localparam int MODE_WAKEUP   = 5;
    localparam int MODE_LINE_SEL = 4;
    localparam int MODE_HI       = 3;
    localparam int MODE_LO       = 2;
    localparam int MODE_CLK_HI   = 1;
    localparam int MODE_CLK_LO   = 0;
    localparam int MODE_BITOP_LO = 5;

    // ==========================================================
    // Bus control register fields
    localparam int BUS_RELEASE_TRIG = 7;
    localparam int BUS_COMMAND_TRIG = 6;
    localparam int BUS_REL_SEEN     = 3;
    localparam int BUS_CMD_SEEN     = 2;
    localparam int BUS_BUSY_ENABLE  = 0;

    // ==========================================================
    // Bit operation and status fields
    localparam int BITOP_IDX_HI  = 2;
    localparam int BITOP_VALUE   = 4;
    localparam int BITOP_TARGET  = 8;
    localparam int STATUS_IRQ    = 0;
    localparam int STATUS_ACTIVE = 1;

    // ==========================================================
    // Clock select codes and divider half periods
    localparam logic [1:0] CLK_EXTERNAL = 2'h0;
    localparam logic [1:0] CLK_TIMER    = 2'h1;
    localparam logic [1:0] CLK_DIV_MID  = 2'h2;
    localparam logic [1:0] CLK_DIV_FAST = 2'h3;
    localparam logic [5:0] HALF_DIV16   = 6'h08;
    localparam logic [5:0] HALF_DIV64   = 6'h20;
    localparam logic [5:0] HALF_DIV8    = 6'h04;
    localparam logic [2:0] LAST_BIT     = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum { MODE_HALT, MODE_THREE_WIRE, MODE_ADDRESSED_BUS, MODE_TWO_WIRE } scm_mode_type;
    typedef enum { REG_MODE, REG_BUS, REG_SLAVE, REG_SHIFT, REG_BITOP, REG_STATUS,
                   REG_NONE } scm_reg_type;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } scm_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scm_axi_rsp_type;

endpackage

// ### verif/scm_checker_assertions.sv
// Checker on the serial mode/control ports.
// Assumes it is bound into scm_serial_ch0_mode_control.
`timescale 1ns/1ps
`default_nettype none
module scm_checker
    import scm_pkg::*;
(
    input wire logic            clock,
    input wire logic            nrst,
    input wire scm_axi_req_type axiReq,
    input wire scm_axi_rsp_type axiRsp,
    input wire logic            clockPinOut,
    input wire logic            clockPinOe,
    input wire logic            serialOutOe,
    input wire logic            busLineAOe,
    input wire logic            busLineBOe,
    input wire logic            serialIrqRequest
);
    // ============================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_one_line; !(busLineAOe && busLineBOe); endproperty
    a_one_line: assert property (p_one_line) else $error("two lines");
    property p_push; serialOutOe |-> !busLineAOe && !busLineBOe; endproperty
    a_push: assert property (p_push) else $error("push pull");
    property p_rst; $rose(nrst) |-> !axiRsp.bvalid && !serialIrqRequest && !clockPinOe; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_held; $fell(serialIrqRequest) |-> $rose(axiRsp.bvalid); endproperty
    a_held: assert property (p_held) else $error("irq lost");
    // Disable may cut a low phase
    property p_half; $fell(clockPinOut) && serialOutOe |=> (!clockPinOut || !serialOutOe)[*3]; endproperty
    a_half: assert property (p_half) else $error("short half");
    property p_idle; $fell(clockPinOut) |-> ##[1:40] clockPinOut; endproperty
    a_idle: assert property (p_idle) else $error("clock stuck");
    property p_rd; $rose(axiRsp.rvalid) |-> $past(axiReq.arvalid) && $past(axiRsp.arready); endproperty
    a_rd: assert property (p_rd) else $error("read answer");
    property p_wr; $rose(axiRsp.bvalid) |-> !$past(axiRsp.awready) && !$past(axiRsp.wready); endproperty
    a_wr: assert property (p_wr) else $error("write early");
endmodule // scm_checker
bind scm_serial_ch0_mode_control scm_checker scm_checker_inst (
    .clock(clock), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp),
    .clockPinOut(clockPinOut), .clockPinOe(clockPinOe), .serialOutOe(serialOutOe),
    .busLineAOe(busLineAOe), .busLineBOe(busLineBOe), .serialIrqRequest(serialIrqRequest));
`default_nettype wire

// ### verif/scm_serial_peer.sv
// Far-side peripheral: sends one byte MSB first.
// Assumes a serial clock idling high and pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
module scm_serial_peer (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       clkLine,
    input  wire logic [7:0] txByte,
    input  wire logic       lineAOe,
    input  wire logic       lineBOe,
    output logic            dataOut,
    output logic            lineA,
    output logic            lineB
);
    logic       clkPrev_reg;
    logic [2:0] count_reg;
    always_ff @(posedge clock) begin
        clkPrev_reg <= clkLine;
        if (!nrst) count_reg <= 3'h0;
        else if (clkPrev_reg && !clkLine) count_reg <= count_reg + 3'h1;
    end
    assign dataOut = txByte[3'h0 - count_reg];
    // Pull-ups keep a released line high
    assign lineA = !lineAOe;
    assign lineB = !lineBOe;
endmodule // scm_serial_peer
`default_nettype wire

// ### verif/testbench.sv
// Bench for the serial mode/control block.
// Assumes the peer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import scm_pkg::*;
;
    logic            clock;
    logic            nrst;
    scm_axi_req_type req;
    scm_axi_rsp_type rsp;
    logic            clkOut, clkOe, soPin, soOe, siPin, aIn, aOe, bIn, bOe, irq;
    int              nErrors = 0;
    int              checked = 0;
    scm_serial_ch0_mode_control scm_serial_ch0_mode_control_inst (
        .clock(clock), .nrst(nrst), .axiReq(req), .axiRsp(rsp), .timerOut(1'b0),
        .clockPinIn(1'b1), .clockPinOut(clkOut), .clockPinOe(clkOe), .serialOutPin(soPin),
        .serialOutOe(soOe), .serialInPin(siPin), .busLineAIn(aIn), .busLineAOut(),
        .busLineAOe(aOe), .busLineBIn(bIn), .busLineBOut(), .busLineBOe(bOe),
        .serialIrqRequest(irq));
    scm_serial_peer scm_serial_peer_inst (
        .clock(clock), .nrst(nrst), .clkLine(clkOe ? clkOut : 1'b1), .txByte(8'h3c),
        .lineAOe(aOe), .lineBOe(bOe), .dataOut(siPin), .lineA(aIn), .lineB(bIn));
    // ============================================
    // Bus tasks
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            nErrors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        do @(negedge clock); while (!(rsp.awready && rsp.wready));
        @(posedge clock);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(negedge clock); while (!rsp.bvalid);
        chk("bresp", 32'(r), 32'(rsp.bresp));
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do @(negedge clock); while (!rsp.arready);
        @(posedge clock);
        req.arvalid <= 1'b0;
        do @(negedge clock); while (!rsp.rvalid);
        chk("rresp", 32'(RESP_OKAY), 32'(rsp.rresp));
        chk("rdata", e, rsp.rdata);
        @(posedge clock);
    endtask
    task automatic t_regs;
        rd(ADDR_MODE_CONTROL, 32'h40);
        rd(ADDR_BUS_CONTROL, 32'h0);
        wr(ADDR_SLAVE_ADDR, 32'h5a);
        wr(ADDR_MODE_CONTROL, 32'h7f);
        rd(ADDR_MODE_CONTROL, 32'h3f);
        wr(ADDR_BIT_OP, 32'h5);
        wr(ADDR_BIT_OP, 32'h17);
        wr(ADDR_SLAVE_ADDR, 32'h0);
        rd(ADDR_MODE_CONTROL, 32'hdf);
        wr(12'h100, 32'h0, RESP_SLVERR);
        wr(ADDR_BUS_CONTROL, 32'hff, RESP_SLVERR);
        rd(ADDR_BUS_CONTROL, 32'h0);
        $display("register test done");
    endtask
    task automatic t_three;
        wr(ADDR_MODE_CONTROL, 32'h83);
        chk("so enable", 32'h1, soOe);
        wr(ADDR_SHIFT, 32'ha5);
        do @(negedge clock); while (!irq);
        @(posedge clock);
        rd(ADDR_SHIFT, 32'h3c);
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_BIT_OP, 32'h116);
        repeat (4) @(posedge clock);
        chk("so latch", 32'h0, soPin);
        wr(ADDR_BIT_OP, 32'h117);
        repeat (4) @(posedge clock);
        chk("so latch", 32'h1, soPin);
        rd(ADDR_BUS_CONTROL, 32'h0);
        $display("three-wire test done");
    endtask
    task automatic t_bus;
        wr(ADDR_MODE_CONTROL, 32'h8a);
        wr(ADDR_BIT_OP, 32'h116);
        repeat (4) @(posedge clock);
        chk("line a", 32'h1, aOe);
        wr(ADDR_MODE_CONTROL, 32'h9e);
        chk("line a", 32'h0, aOe);
        chk("line b", 32'h1, bOe);
        wr(ADDR_BIT_OP, 32'h117);
        wr(ADDR_STATUS, 32'h1);
        wr(ADDR_SHIFT, 32'hff);
        do @(negedge clock); while (!irq);
        @(posedge clock);
        rd(ADDR_SHIFT, 32'hff);
        $display("bus test done");
    endtask
    task automatic t_off;
        wr(ADDR_MODE_CONTROL, 32'h83);
        wr(ADDR_SHIFT, 32'h55);
        repeat (12) @(posedge clock);
        wr(ADDR_MODE_CONTROL, 32'h3);
        rd(ADDR_STATUS, 32'h1);
        chk("clock pin", 32'h1, 32'(clkOut & clkOe));
        wr(ADDR_STATUS, 32'h1);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_MODE_CONTROL, 32'h0);
        chk("clock oe", 32'h0, clkOe);
        $display("disable test done");
    endtask
    task automatic stopTest;
        $display("checked %0d mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_three();
        t_bus();
        t_off();
        stopTest();
    end
    initial begin
        #200us;
        nErrors++;
        stopTest();
    end
endmodule // testbench
`default_nettype wire
